// >>> common/tssr_consts.svh
`ifndef TSSR_CONSTS_SVH
`define TSSR_CONSTS_SVH
// Overview of operation
// - Seven-bit slider field, position or volume mode
// - Position interpolated from three sensors, sixteen steps
// - Reported positions lie between 2 and 98
// - Slide reports where it ended
// - Deep sleep clears slider in position mode
// - Read clears position; next interrupt reloads it
// - Repeat updates slider regardless of reads
// - Volume kept within 0 to 100
// - Slide interrupts add or subtract step
// - Tap changes volume by one
// - Press-and-hold changes volume one per repeat
// - Host may write the volume value
// - Fixed identification byte at two addresses
// - Four-bit step field, reset value one
// - Noise flags from analog or RF detector
// - Noisy sensor delta forced to zero
// - Noise flags follow detector, never latch
// - Noisy samples discarded unless discard disabled
// - Lid flag needs enable and count over threshold or touch
// - Touched sensor also shows lid flag
// - Lid flags follow queued result, no latch
// - GPIO change flags, inputs only, clear on read

`define TSSR_ADDR_SLIDER     8'h06
`define TSSR_ADDR_MAKER      8'h08
`define TSSR_ADDR_STEP       8'h09
`define TSSR_ADDR_NOISE_LO   8'h0a
`define TSSR_ADDR_NOISE_HI   8'h0b
`define TSSR_ADDR_LID_LO     8'h0c
`define TSSR_ADDR_LID_HI     8'h0d
`define TSSR_ADDR_GPIO       8'h0e
`define TSSR_ADDR_MAKER_ALT  8'hfe
`define TSSR_SLIDER_RST      7'h00
`define TSSR_STEP_RST        4'h1
`define TSSR_VOL_MAX         7'h64
`define TSSR_POS_MIN         7'h02
`define TSSR_POS_MAX         7'h62
`define TSSR_POS_PER_SENSOR  7'h10
`define TSSR_RF_BIT          7
`endif

// >>> common/tssr_pkg.sv
package tssr_pkg;
   typedef enum logic [1:0] {
      TSSR_EV_NONE,
      TSSR_EV_SLIDE,
      TSSR_EV_TAP,
      TSSR_EV_HOLD
   } tssr_event_e;
   typedef logic [6:0] tssr_slider_t;
endpackage

// >>> verilog/tssr_regs.sv
`include "tssr_consts.svh"

module tssr_regs
   import tssr_pkg::*;
#(
   parameter int          NUM_SENSORS = 14,
   parameter int          NUM_GPIO    = 8,
   parameter logic [7:0]  MAKER_CODE  = 8'ha7  // Arbitrary identification value
) (
   input  wire logic                   clk_sys_i,
   input  wire logic                   reset_i,
   // Register access port
   input  wire logic [7:0]             reg_addr_i,
   input  wire logic                   reg_rd_i,
   input  wire logic                   reg_wr_i,
   input  wire logic [7:0]             reg_wdata_i,
   output logic      [7:0]             reg_rdata_o,
   // Configuration and power state
   input  wire logic                   slider_mode_select_i,
   input  wire logic                   deep_sleep_entry_i,
   input  wire logic                   analog_noise_discard_off_i,
   input  wire logic                   rf_noise_discard_off_i,
   input  wire logic                   lid_detect_en_i,
   // Slider activity, one-cycle event with direction
   input  wire logic                   alert_pulse_i,
   input  wire logic [1:0]             slider_event_i,
   input  wire logic                   slider_up_i,
   input  wire logic                   slider_down_i,
   input  wire logic [7:0]             slider_sense_i [3],
   input  wire logic [3:0]             slider_peak_idx_i,
   // Analog front end, per sensor, plus one RF noise flag
   input  wire logic [NUM_SENSORS-1:0] ana_noise_i,
   input  wire logic                   rf_noise_i,
   input  wire logic [7:0]             raw_delta_i [NUM_SENSORS],
   input  wire logic [NUM_SENSORS-1:0] lid_over_queued_i,
   input  wire logic [NUM_SENSORS-1:0] touch_queued_i,
   // GPIO pins
   input  wire logic [NUM_GPIO-1:0]    gpio_pin_i,
   input  wire logic [NUM_GPIO-1:0]    gpio_is_input_i,
   // Outputs
   output logic      [7:0]             delta_count_o [NUM_SENSORS],
   output logic      [NUM_SENSORS-1:0] sample_discard_o,
   output logic      [6:0]             slider_value_o
);

   ////////////////////////////////////////////////////////////////////////////
   tssr_slider_t                slider_r;
   tssr_slider_t                slider_nxt;
   logic         [3:0]          step_r;
   logic         [NUM_SENSORS-1:0] noise_r;
   logic                        rf_flag_r;
   logic         [NUM_SENSORS-1:0] lid_r;
   logic         [NUM_GPIO-1:0] gpio_meta_r;
   logic         [NUM_GPIO-1:0] gpio_sync_r;
   logic         [NUM_GPIO-1:0] gpio_last_r;
   logic         [NUM_GPIO-1:0] gpio_flag_r;
   logic                        rf_meta_r;
   logic                        rf_sync_r;
   logic         [NUM_SENSORS-1:0] ana_meta_r;
   logic         [NUM_SENSORS-1:0] ana_sync_r;
   tssr_event_e                 ev;
   logic                        rd_slider;
   logic                        rd_gpio;
   logic         [7:0]          pos_calc;
   logic         [7:0]          vol_calc;
   logic         [8:0]          wsum;
   logic         [8:0]          wtot;
   logic         [7:0]          delta;

   assign ev        = tssr_event_e'(slider_event_i);
   assign rd_slider = reg_rd_i && (reg_addr_i == `TSSR_ADDR_SLIDER);
   assign rd_gpio   = reg_rd_i && (reg_addr_i == `TSSR_ADDR_GPIO);

   ////////////////////////////////////////////////////////////////////////////
   // Analog flags arrive from another domain
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ana_meta_r <= '0;
         ana_sync_r <= '0;
         rf_meta_r  <= 1'b0;
         rf_sync_r  <= 1'b0;
      end else begin
         ana_meta_r <= ana_noise_i;
         ana_sync_r <= ana_meta_r;
         rf_meta_r  <= rf_noise_i;
         rf_sync_r  <= rf_meta_r;
      end
   end

   // Flags follow the detector each cycle, no latching
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         noise_r   <= '0;
         rf_flag_r <= 1'b0;
      end else begin
         noise_r   <= ana_sync_r | {{(NUM_SENSORS-1){1'b0}}, rf_sync_r};
         rf_flag_r <= rf_sync_r;
      end
   end

   // Noisy sample dropped unless its discard is turned off
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sample_discard_o <= '0;
      end else begin
         sample_discard_o <= (ana_sync_r & {NUM_SENSORS{~analog_noise_discard_off_i}})
            | ({{(NUM_SENSORS-1){1'b0}}, rf_sync_r}
               & {NUM_SENSORS{~rf_noise_discard_off_i}});
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         delta_count_o <= '{default: 8'h00};
      end else begin
         for (int i = 0; i < NUM_SENSORS; i++) begin
            delta_count_o[i] <= noise_r[i] ? 8'h00 : raw_delta_i[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lid inputs are already queue-filtered upstream
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         lid_r <= '0;
      end else if (!lid_detect_en_i) begin
         lid_r <= '0;
      end else begin
         lid_r <= lid_over_queued_i | touch_queued_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         gpio_meta_r <= '0;
         gpio_sync_r <= '0;
         gpio_last_r <= '0;
      end else begin
         gpio_meta_r <= gpio_pin_i;
         gpio_sync_r <= gpio_meta_r;
         gpio_last_r <= gpio_sync_r;
      end
   end

   // New change wins over a same-cycle read clear
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         gpio_flag_r <= '0;
      end else begin
         gpio_flag_r <= ((rd_gpio ? '0 : gpio_flag_r)
            | (gpio_sync_r ^ gpio_last_r)) & gpio_is_input_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Weighted centroid over peak sensor and its neighbours
   always_comb begin
      wsum = 9'(slider_sense_i[2]) - 9'(slider_sense_i[0]);
      wtot = 9'(slider_sense_i[0]) + 9'(slider_sense_i[1]) + 9'(slider_sense_i[2]);
      delta = 8'h00;
      if (wtot != 9'h000) begin
         delta = 8'((13'(wsum[7:0]) * 13'h010) / 13'(wtot));
      end
      pos_calc = 8'(`TSSR_POS_MIN) + 8'(slider_peak_idx_i) * 8'(`TSSR_POS_PER_SENSOR);
      if (slider_sense_i[2] >= slider_sense_i[0]) begin
         pos_calc = pos_calc + delta;
      end else begin
         pos_calc = pos_calc - 8'((13'(-wsum[7:0]) * 13'h010) / 13'(wtot | 9'h001));
      end
      if (pos_calc[7] || pos_calc < 8'(`TSSR_POS_MIN)) begin
         pos_calc = 8'(`TSSR_POS_MIN);
      end else if (pos_calc > 8'(`TSSR_POS_MAX)) begin
         pos_calc = 8'(`TSSR_POS_MAX);
      end
   end

   // Volume step by event kind, clamped
   always_comb begin
      vol_calc = {1'b0, slider_r};
      if (ev == TSSR_EV_SLIDE) begin
         if (slider_up_i) begin
            vol_calc = 8'(slider_r) + 8'(step_r);
         end else if (slider_down_i) begin
            vol_calc = (slider_r > 7'(step_r)) ? 8'(slider_r - 7'(step_r)) : 8'h00;
         end
      end else if (ev == TSSR_EV_TAP || ev == TSSR_EV_HOLD) begin
         if (slider_up_i) begin
            vol_calc = 8'(slider_r) + 8'h01;
         end else if (slider_down_i && slider_r != 7'h00) begin
            vol_calc = 8'(slider_r) - 8'h01;
         end
      end
      if (vol_calc > 8'(`TSSR_VOL_MAX)) begin
         vol_calc = 8'(`TSSR_VOL_MAX);
      end
   end

   always_comb begin
      slider_nxt = slider_r;
      if (slider_mode_select_i) begin
         if (reg_wr_i && reg_addr_i == `TSSR_ADDR_SLIDER) begin
            slider_nxt = (reg_wdata_i[6:0] > `TSSR_VOL_MAX) ? `TSSR_VOL_MAX
                                                            : reg_wdata_i[6:0];
         end
         if (alert_pulse_i && ev != TSSR_EV_NONE) begin
            slider_nxt = vol_calc[6:0];
         end
      end else begin
         if (rd_slider) begin
            slider_nxt = `TSSR_SLIDER_RST;
         end
         // Every alert with an event, including repeats, loads the latest position unless deep sleep entry clears it
         if (alert_pulse_i && ev != TSSR_EV_NONE) begin
            slider_nxt = pos_calc[6:0];
         end
         if (deep_sleep_entry_i) begin
            slider_nxt = `TSSR_SLIDER_RST;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         slider_r <= `TSSR_SLIDER_RST;
      end else begin
         slider_r <= slider_nxt;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         step_r <= `TSSR_STEP_RST;
      end else if (reg_wr_i && reg_addr_i == `TSSR_ADDR_STEP) begin
         step_r <= reg_wdata_i[3:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         slider_value_o <= `TSSR_SLIDER_RST;
      end else begin
         slider_value_o <= slider_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `TSSR_ADDR_SLIDER:    reg_rdata_o <= {1'b0, slider_r};
            `TSSR_ADDR_MAKER,
            `TSSR_ADDR_MAKER_ALT: reg_rdata_o <= MAKER_CODE;
            `TSSR_ADDR_STEP:      reg_rdata_o <= {4'h0, step_r};
            `TSSR_ADDR_NOISE_LO: begin
               reg_rdata_o <= {rf_flag_r, noise_r[6:0]};
            end
            `TSSR_ADDR_NOISE_HI:  reg_rdata_o <= {1'b0, noise_r[13:7]};
            `TSSR_ADDR_LID_LO:    reg_rdata_o <= {1'b0, lid_r[6:0]};
            `TSSR_ADDR_LID_HI:    reg_rdata_o <= {1'b0, lid_r[13:7]};
            `TSSR_ADDR_GPIO:      reg_rdata_o <= gpio_flag_r;
            default:              reg_rdata_o <= 8'h00;
         endcase
      end
   end

endmodule

// >>> tb/tssr_regs_checker.sv
module tssr_regs_checker
   import tssr_pkg::*;
#(
   parameter int         NUM_SENSORS = 14,
   parameter logic [7:0] MAKER_CODE  = 8'ha7
) (
   input wire logic                   clk_sys_i,
   input wire logic                   reset_i,
   input wire logic [7:0]             reg_addr_i,
   input wire logic                   reg_rd_i,
   input wire logic                   reg_wr_i,
   input wire logic [7:0]             reg_rdata_o,
   input wire logic                   slider_mode_select_i,
   input wire logic                   deep_sleep_entry_i,
   input wire logic                   alert_pulse_i,
   input wire logic [1:0]             slider_event_i,
   input wire logic                   slider_up_i,
   input wire logic [NUM_SENSORS-1:0] ana_noise_i,
   input wire logic [7:0]             delta_count_o [NUM_SENSORS],
   input wire logic [6:0]             slider_value_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   sequence s_rd(a);
      reg_rd_i && reg_addr_i == a;
   endsequence
   // Host write excluded: the alert overrides a preset in the same cycle
   sequence s_tap_up;
      alert_pulse_i && slider_mode_select_i && slider_event_i == TSSR_EV_TAP
      && slider_up_i && slider_value_o < 7'h64 && !reg_wr_i;
   endsequence
   property p_id; s_rd(8'h08) |=> reg_rdata_o == MAKER_CODE; endproperty
   a_id: assert property (p_id) else $error("id read wrong");
   property p_id_alt; s_rd(8'hfe) |=> reg_rdata_o == MAKER_CODE; endproperty
   a_id_alt: assert property (p_id_alt) else $error("id alias wrong");
   property p_rd_clr;
      s_rd(8'h06) ##0 !slider_mode_select_i && !alert_pulse_i |=> slider_value_o == 7'h00;
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("position not cleared by read");
   property p_deep; deep_sleep_entry_i && !slider_mode_select_i |=> slider_value_o == 7'h00; endproperty
   a_deep: assert property (p_deep) else $error("deep sleep kept position");
   property p_vol_rng; slider_mode_select_i |-> slider_value_o <= 7'h64; endproperty
   a_vol_rng: assert property (p_vol_rng) else $error("volume above limit");
   property p_pos_rng;
      alert_pulse_i && !slider_mode_select_i && slider_event_i != TSSR_EV_NONE
      && !deep_sleep_entry_i |=> slider_value_o inside {[7'h02:7'h62]};
   endproperty
   a_pos_rng: assert property (p_pos_rng) else $error("position out of range");
   property p_noise; ana_noise_i[0] [*5] |-> delta_count_o[0] == 8'h00; endproperty
   a_noise: assert property (p_noise) else $error("noisy delta not zero");
   property p_tap; s_tap_up |=> slider_value_o == $past(slider_value_o) + 7'h01; endproperty
   a_tap: assert property (p_tap) else $error("tap up step wrong");
endmodule
bind tssr_regs tssr_regs_checker #(.NUM_SENSORS(NUM_SENSORS), .MAKER_CODE(MAKER_CODE)) u_chk (
   .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
   .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .slider_mode_select_i(slider_mode_select_i),
   .deep_sleep_entry_i(deep_sleep_entry_i), .alert_pulse_i(alert_pulse_i),
   .slider_event_i(slider_event_i), .slider_up_i(slider_up_i), .ana_noise_i(ana_noise_i),
   .delta_count_o(delta_count_o), .slider_value_o(slider_value_o));

// >>> tb/tssr_host.sv
module tssr_host (
   input  wire logic       clk_sys_i,
   input  wire logic [7:0] reg_rdata_i,
   output logic      [7:0] reg_addr_o = 8'h00,
   output logic            reg_rd_o = 1'b0,
   output logic            reg_wr_o = 1'b0,
   output logic      [7:0] reg_wdata_o = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released bus shows inverted values so a stale address cannot pass
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge clk_sys_i);
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      d = reg_rdata_i;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk_sys_i);
      reg_addr_o = a;
      reg_wdata_o = v;
      reg_wr_o = 1'b1;
      @(negedge clk_sys_i);
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~v;
   endtask
endmodule

// >>> tb/tssr_regs_tb.sv
module tssr_regs_tb
   import tssr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ID = 8'h3c; // Arbitrary identification value
   localparam logic [7:0] RA [10] = '{8'h06, 8'h08, 8'hfe, 8'h09, 8'h0a, 8'h0b, 8'h0c,
                                      8'h0d, 8'h0e, 8'h40};
   localparam logic [7:0] RV [10] = '{8'h00, ID, ID, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
                                      8'h00, 8'h00};
   localparam tssr_event_e VK [5] = '{TSSR_EV_SLIDE, TSSR_EV_SLIDE, TSSR_EV_TAP,
                                      TSSR_EV_HOLD, TSSR_EV_HOLD};
   localparam logic [4:0] VU = 5'b00101;
   localparam logic [7:0] VE [5] = '{8'h37, 8'h32, 8'h33, 8'h32, 8'h31};
   logic        clk_sys_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        mode = 1'b0;
   logic        deep = 1'b0;
   logic        alert = 1'b0;
   logic        up = 1'b0;
   logic        rf = 1'b0;
   logic        lid_en = 1'b0;
   logic [1:0]  ev = 2'h0;
   logic [3:0]  peak = 4'h0;
   logic [7:0]  sense [3] = '{8'h00, 8'h50, 8'h00};
   logic [13:0] ana = 14'h0000;
   logic [13:0] lid_ov = 14'h0000;
   logic [13:0] touch_q = 14'h0000;
   logic        aoff = 1'b0;
   logic        rfoff = 1'b0;
   logic [7:0]  raw [14] = '{default: 8'h20};
   logic [7:0]  gpio = 8'h00;
   logic [7:0]  gpio_in = 8'h00;
   logic [7:0]  addr, wdata, rdata, d;
   logic        rd, wr;
   logic [7:0]  delta [14];
   logic [13:0] disc;
   logic [6:0]  sval;
   int          num_errors = 0;
   int          cmp_count = 0;
   tssr_host HOST (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
                   .reg_rd_o(rd), .reg_wr_o(wr), .reg_wdata_o(wdata));
   tssr_regs #(.MAKER_CODE(ID)) DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .slider_mode_select_i(mode), .deep_sleep_entry_i(deep),
      .analog_noise_discard_off_i(aoff), .rf_noise_discard_off_i(rfoff),
      .lid_detect_en_i(lid_en), .alert_pulse_i(alert), .slider_event_i(ev),
      .slider_up_i(up), .slider_down_i(!up), .slider_sense_i(sense),
      .slider_peak_idx_i(peak), .ana_noise_i(ana), .rf_noise_i(rf), .raw_delta_i(raw),
      .lid_over_queued_i(lid_ov), .touch_queued_i(touch_q), .gpio_pin_i(gpio),
      .gpio_is_input_i(gpio_in), .delta_count_o(delta), .sample_discard_o(disc),
      .slider_value_o(sval));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      HOST.rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask
   task automatic pulse(input tssr_event_e k, input logic u, input logic [3:0] p);
      @(negedge clk_sys_i);
      alert = 1'b1;
      ev = k;
      up = u;
      peak = p;
      @(negedge clk_sys_i);
      alert = 1'b0;
      ev = TSSR_EV_NONE;
   endtask
   task automatic stop_test;
      $display("Compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      #200us;
      num_errors++;
      stop_test();
   end
   initial begin
      repeat (6) @(negedge clk_sys_i);
      reset_i = 1'b0;
      foreach (RA[i]) rchk(RA[i], RV[i]);
      $display("T1 reset done");
      pulse(TSSR_EV_TAP, 1'b1, 4'h3);
      rchk(8'h06, 8'h32);
      rchk(8'h06, 8'h00);
      pulse(TSSR_EV_SLIDE, 1'b1, 4'h6);
      rchk(8'h06, 8'h62);
      pulse(TSSR_EV_SLIDE, 1'b0, 4'h0);
      chk("slider", 8'h02, {1'b0, sval});
      deep = 1'b1;
      @(negedge clk_sys_i);
      deep = 1'b0;
      rchk(8'h06, 8'h00);
      $display("T2 position done");
      mode = 1'b1;
      HOST.wr(8'h06, 8'h32);
      HOST.wr(8'h09, 8'h05);
      rchk(8'h09, 8'h05);
      foreach (VK[i]) begin
         pulse(VK[i], VU[i], 4'h3);
         rchk(8'h06, VE[i]);
      end
      HOST.wr(8'h06, 8'h62);
      pulse(TSSR_EV_SLIDE, 1'b1, 4'h6);
      rchk(8'h06, 8'h64);
      HOST.wr(8'h06, 8'h03);
      pulse(TSSR_EV_SLIDE, 1'b0, 4'h0);
      rchk(8'h06, 8'h00);
      mode = 1'b0;
      $display("T3 volume done");
      ana[0] = 1'b1;
      repeat (5) @(negedge clk_sys_i);
      rchk(8'h0a, 8'h01);
      chk("delta", 8'h00, delta[0]);
      chk("discard", 8'h01, {7'h00, disc[0]});
      aoff = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      chk("discard", 8'h00, {7'h00, disc[0]});
      aoff = 1'b0;
      ana[0] = 1'b0;
      rf = 1'b1;
      repeat (5) @(negedge clk_sys_i);
      rchk(8'h0a, 8'h81);
      chk("discard", 8'h01, {7'h00, disc[0]});
      rfoff = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      chk("discard", 8'h00, {7'h00, disc[0]});
      rfoff = 1'b0;
      rf = 1'b0;
      repeat (5) @(negedge clk_sys_i);
      rchk(8'h0a, 8'h00);
      chk("delta", 8'h20, delta[0]);
      $display("T4 noise done");
      lid_en = 1'b1;
      lid_ov = 14'h0100;
      touch_q = 14'h0001;
      repeat (3) @(negedge clk_sys_i);
      rchk(8'h0d, 8'h02);
      rchk(8'h0c, 8'h01);
      touch_q = 14'h0000;
      lid_ov = 14'h0000;
      repeat (3) @(negedge clk_sys_i);
      rchk(8'h0c, 8'h00);
      lid_ov = 14'h0100;
      lid_en = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      rchk(8'h0d, 8'h00);
      gpio_in = 8'h0f;
      gpio = 8'h11;
      repeat (6) @(negedge clk_sys_i);
      rchk(8'h0e, 8'h01);
      rchk(8'h0e, 8'h00);
      $display("T5 lid and pins done");
      stop_test();
   end
endmodule
